//--- pkg/tcr_pkg.sv
package tcr_pkg;

  // Register offsets as seen by the I/O port instructions or the extended space
  localparam logic [7:0] OFS_CAP1_LO  = 8'h26;
  localparam logic [7:0] OFS_CAP1_HI  = 8'h27;
  localparam logic [7:0] OFS_FLAG     = 8'h36;
  localparam logic [7:0] OFS_MASK     = 8'h37;
  localparam logic [7:0] OFS_EFLAG    = 8'h7C;
  localparam logic [7:0] OFS_EMASK    = 8'h7D;
  localparam logic [7:0] OFS_CAP3_LO  = 8'h80;
  localparam logic [7:0] OFS_CAP3_HI  = 8'h81;
  localparam logic [7:0] OFS_CMPC3_LO = 8'h82;
  localparam logic [7:0] OFS_CMPC3_HI = 8'h83;

  // Address map of the two access paths
  localparam logic [7:0] IO_PORT_LAST = 8'h3F;
  localparam logic [7:0] DSPACE_SHIFT = 8'h20;
  localparam logic [7:0] EXT_IO_BASE  = 8'h60;

  // Bit positions inside the mask and flag bytes
  localparam int BIT_CAP     = 5;
  localparam int BIT_CMP_A   = 4;
  localparam int BIT_CMP_B   = 3;
  localparam int BIT_OVF     = 2;
  localparam int BIT_CMP_C3  = 1;
  localparam int BIT_CMP_C1  = 0;

  // Values after reset
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // One CPU access to the I/O space
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       dspace;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tcr_io_req_type;

  // One bit per interrupt source of both timers
  typedef struct packed {
    logic t1_cap;
    logic t1_cmp_a;
    logic t1_cmp_b;
    logic t1_ovf;
    logic t1_cmp_c;
    logic t3_cap;
    logic t3_cmp_a;
    logic t3_cmp_b;
    logic t3_ovf;
    logic t3_cmp_c;
  } tcr_src_type;

  // Events produced by the counter logic outside this block
  typedef struct packed {
    logic t1_top;
    logic t1_cmp_a;
    logic t1_cmp_b;
    logic t1_ovf;
    logic t1_cmp_c;
    logic t3_top;
    logic t3_cmp_a;
    logic t3_cmp_b;
    logic t3_ovf;
  } tcr_ext_evt_type;

  // Capture setup of one timer
  typedef struct packed {
    logic rising;
    logic top_is_cap;
  } tcr_cfg_type;

  // Sources whose enables live in the extended mask byte
  localparam tcr_src_type EXT_SRC_MASK = 10'b0000111111;

endpackage

//--- rtl/tcr_capture_chan.sv
module tcr_capture_chan
  import tcr_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        cap_pin,
  input  wire logic        alt_pin,
  input  wire logic        use_alt,
  input  wire logic        rising,
  input  wire logic        capture_off,
  input  wire logic [15:0] count,
  input  wire logic        load_en,
  input  wire logic [15:0] load_value,
  output logic      [15:0] value,
  output logic             event_pulse
);

  logic        pin_meta;
  logic        pin_sync;
  logic        alt_meta;
  logic        alt_sync;
  logic        sel_last;
  logic        sel_now;
  logic        edge_seen;
  logic [15:0] next_value;
  logic        next_event;

  // Source choice and edge qualification
  always_comb begin
    sel_now    = use_alt ? alt_sync : pin_sync;
    edge_seen  = rising ? (sel_now & ~sel_last) : (~sel_now & sel_last);
    next_event = edge_seen & ~capture_off;
    next_value = value;
    if (load_en) begin
      next_value = load_value;
    end
    if (next_event) begin
      next_value = count;
    end
  end

  // Two-stage synchronisers, edge history and capture register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pin_meta    <= 1'b0;
      pin_sync    <= 1'b0;
      alt_meta    <= 1'b0;
      alt_sync    <= 1'b0;
      sel_last    <= 1'b0;
      value       <= RST_WORD;
      event_pulse <= 1'b0;
    end else if (ce) begin
      pin_meta    <= cap_pin;
      pin_sync    <= pin_meta;
      alt_meta    <= alt_pin;
      alt_sync    <= alt_meta;
      sel_last    <= sel_now;
      value       <= next_value;
      event_pulse <= next_event;
    end
  end

  default clocking dclk @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence seq_qual_edge;
    ce && edge_seen && !capture_off;
  endsequence

  AST_CAPTURE_COPIES: assert property (seq_qual_edge |=> event_pulse && value == $past(count))
    else $error("capture did not copy the counter");

  AST_CAPTURE_OFF: assert property (ce && capture_off |=> !event_pulse)
    else $error("capture event while capture is the period setting");

endmodule

//--- rtl/tcr_regs.sv
module tcr_regs
  import tcr_pkg::*;
(
  input  wire logic            clock,
  input  wire logic            nrst,
  input  wire logic            ce,
  input  wire tcr_io_req_type  io_req,
  output logic      [7:0]      io_rdata,
  input  wire logic            global_irq_en,
  input  wire logic            compat_mode,
  input  wire logic            t1_cap_pin,
  input  wire logic            t3_cap_pin,
  input  wire logic            cmp_out,
  input  wire logic            t1_cap_from_cmp,
  input  wire tcr_cfg_type     t1_cfg,
  input  wire tcr_cfg_type     t3_cfg,
  input  wire logic [15:0]     t1_count,
  input  wire logic [15:0]     t3_count,
  input  wire logic            t3_tick,
  input  wire tcr_ext_evt_type ext_evt,
  input  wire tcr_src_type     irq_ack,
  output tcr_src_type          irq_req,
  output logic      [15:0]     t1_top_value,
  output logic      [15:0]     t3_top_value,
  output logic      [15:0]     t3_cmp_c_value
);

  logic        hit;
  logic [7:0]  eff_off;
  logic        rd;
  logic        wr;
  logic [7:0]  wd;
  tcr_src_type flag;
  tcr_src_type en;
  tcr_src_type en_eff;
  tcr_src_type set;
  tcr_src_type clr;
  tcr_src_type next_flag;
  tcr_src_type next_en;
  tcr_src_type next_irq;
  logic [7:0]  temp;
  logic [7:0]  next_temp;
  logic [15:0] next_cmpc;
  logic [7:0]  next_rdata;
  logic [7:0]  flag_byte;
  logic [7:0]  eflag_byte;
  logic [7:0]  mask_byte;
  logic [7:0]  emask_byte;
  logic        cap1_evt;
  logic        cap3_evt;
  logic        cap1_load;
  logic        cap3_load;
  logic        cmpc_match;

  // Address decode of the two access paths
  always_comb begin
    eff_off = io_req.addr;
    hit     = 1'b0;
    if (!io_req.dspace) begin
      hit = (io_req.addr <= IO_PORT_LAST);
    end else if (io_req.addr < EXT_IO_BASE) begin
      hit     = (io_req.addr >= DSPACE_SHIFT);
      eff_off = io_req.addr - DSPACE_SHIFT;
    end else begin
      hit = 1'b1;
    end
    rd = ce & io_req.rd & hit;
    wr = ce & io_req.wr & hit;
    wd = io_req.wdata;
  end

  // Capture writes commit the staged high byte with the low byte
  always_comb begin
    cap1_load = wr && (eff_off == OFS_CAP1_LO);
    cap3_load = wr && (eff_off == OFS_CAP3_LO);
  end

  // Timer 1 capture, optionally from the comparator
  tcr_capture_chan u_cap1 (
    .clock       (clock),
    .nrst        (nrst),
    .ce          (ce),
    .cap_pin     (t1_cap_pin),
    .alt_pin     (cmp_out),
    .use_alt     (t1_cap_from_cmp),
    .rising      (t1_cfg.rising),
    .capture_off (t1_cfg.top_is_cap),
    .count       (t1_count),
    .load_en     (cap1_load),
    .load_value  ({temp, wd}),
    .value       (t1_top_value),
    .event_pulse (cap1_evt)
  );

  // Timer 3 capture, pin only
  tcr_capture_chan u_cap3 (
    .clock       (clock),
    .nrst        (nrst),
    .ce          (ce),
    .cap_pin     (t3_cap_pin),
    .alt_pin     (1'b0),
    .use_alt     (1'b0),
    .rising      (t3_cfg.rising),
    .capture_off (t3_cfg.top_is_cap),
    .count       (t3_count),
    .load_en     (cap3_load),
    .load_value  ({temp, wd}),
    .value       (t3_top_value),
    .event_pulse (cap3_evt)
  );

  // Byte views of flags and enables
  always_comb begin
    flag_byte              = RST_BYTE;
    flag_byte[BIT_CAP]     = flag.t1_cap;
    flag_byte[BIT_CMP_A]   = flag.t1_cmp_a;
    flag_byte[BIT_CMP_B]   = flag.t1_cmp_b;
    flag_byte[BIT_OVF]     = flag.t1_ovf;
    eflag_byte             = RST_BYTE;
    eflag_byte[BIT_CAP]    = flag.t3_cap;
    eflag_byte[BIT_CMP_A]  = flag.t3_cmp_a;
    eflag_byte[BIT_CMP_B]  = flag.t3_cmp_b;
    eflag_byte[BIT_OVF]    = flag.t3_ovf;
    eflag_byte[BIT_CMP_C3] = flag.t3_cmp_c;
    eflag_byte[BIT_CMP_C1] = flag.t1_cmp_c;
    mask_byte              = RST_BYTE;
    mask_byte[BIT_CAP]     = en.t1_cap;
    mask_byte[BIT_CMP_A]   = en.t1_cmp_a;
    mask_byte[BIT_CMP_B]   = en.t1_cmp_b;
    mask_byte[BIT_OVF]     = en.t1_ovf;
    emask_byte             = RST_BYTE;
    if (!compat_mode) begin
      emask_byte[BIT_CAP]    = en.t3_cap;
      emask_byte[BIT_CMP_A]  = en.t3_cmp_a;
      emask_byte[BIT_CMP_B]  = en.t3_cmp_b;
      emask_byte[BIT_OVF]    = en.t3_ovf;
      emask_byte[BIT_CMP_C3] = en.t3_cmp_c;
      emask_byte[BIT_CMP_C1] = en.t1_cmp_c;
    end
  end

  // Event sources, clears and flag update
  always_comb begin
    cmpc_match     = t3_tick && (t3_count == t3_cmp_c_value);
    set.t1_cap     = cap1_evt | (ext_evt.t1_top & t1_cfg.top_is_cap);
    set.t1_cmp_a   = ext_evt.t1_cmp_a;
    set.t1_cmp_b   = ext_evt.t1_cmp_b;
    set.t1_ovf     = ext_evt.t1_ovf;
    set.t1_cmp_c   = ext_evt.t1_cmp_c;
    set.t3_cap     = cap3_evt | (ext_evt.t3_top & t3_cfg.top_is_cap);
    set.t3_cmp_a   = ext_evt.t3_cmp_a;
    set.t3_cmp_b   = ext_evt.t3_cmp_b;
    set.t3_ovf     = ext_evt.t3_ovf;
    set.t3_cmp_c   = cmpc_match;
    clr            = irq_ack;
    if (wr && eff_off == OFS_FLAG) begin
      clr.t1_cap   = irq_ack.t1_cap   | wd[BIT_CAP];
      clr.t1_cmp_a = irq_ack.t1_cmp_a | wd[BIT_CMP_A];
      clr.t1_cmp_b = irq_ack.t1_cmp_b | wd[BIT_CMP_B];
      clr.t1_ovf   = irq_ack.t1_ovf   | wd[BIT_OVF];
    end
    if (wr && eff_off == OFS_EFLAG) begin
      clr.t3_cap   = irq_ack.t3_cap   | wd[BIT_CAP];
      clr.t3_cmp_a = irq_ack.t3_cmp_a | wd[BIT_CMP_A];
      clr.t3_cmp_b = irq_ack.t3_cmp_b | wd[BIT_CMP_B];
      clr.t3_ovf   = irq_ack.t3_ovf   | wd[BIT_OVF];
      clr.t3_cmp_c = irq_ack.t3_cmp_c | wd[BIT_CMP_C3];
      clr.t1_cmp_c = irq_ack.t1_cmp_c | wd[BIT_CMP_C1];
    end
    next_flag = tcr_src_type'((flag & ~clr) | set);                      // Set beats clear
  end

  // Enable registers and interrupt request gating
  always_comb begin
    next_en = en;
    if (wr && eff_off == OFS_MASK) begin
      next_en.t1_cap   = wd[BIT_CAP];
      next_en.t1_cmp_a = wd[BIT_CMP_A];
      next_en.t1_cmp_b = wd[BIT_CMP_B];
      next_en.t1_ovf   = wd[BIT_OVF];
    end
    if (wr && eff_off == OFS_EMASK && !compat_mode) begin
      next_en.t3_cap   = wd[BIT_CAP];
      next_en.t3_cmp_a = wd[BIT_CMP_A];
      next_en.t3_cmp_b = wd[BIT_CMP_B];
      next_en.t3_ovf   = wd[BIT_OVF];
      next_en.t3_cmp_c = wd[BIT_CMP_C3];
      next_en.t1_cmp_c = wd[BIT_CMP_C1];
    end
    en_eff   = compat_mode ? tcr_src_type'(en & ~EXT_SRC_MASK) : en;
    next_irq = tcr_src_type'(en_eff & flag & {$bits(tcr_src_type){global_irq_en}});
  end

  // Read mux, shared temporary byte and compare C register
  always_comb begin
    next_rdata = io_rdata;
    next_temp  = temp;
    next_cmpc  = t3_cmp_c_value;
    if (rd) begin
      case (eff_off)
        OFS_CAP1_LO: begin
          next_rdata = t1_top_value[7:0];
          next_temp  = t1_top_value[15:8];
        end
        OFS_CAP3_LO: begin
          next_rdata = t3_top_value[7:0];
          next_temp  = t3_top_value[15:8];
        end
        OFS_CMPC3_LO: begin
          next_rdata = t3_cmp_c_value[7:0];
          next_temp  = t3_cmp_c_value[15:8];
        end
        OFS_CAP1_HI, OFS_CAP3_HI, OFS_CMPC3_HI: begin
          next_rdata = temp;
        end
        OFS_FLAG:  next_rdata = flag_byte;
        OFS_EFLAG: next_rdata = eflag_byte;
        OFS_MASK:  next_rdata = mask_byte;
        OFS_EMASK: next_rdata = emask_byte;
        default:   next_rdata = RST_BYTE;
      endcase
    end
    if (wr) begin
      case (eff_off)
        OFS_CAP1_HI, OFS_CAP3_HI, OFS_CMPC3_HI: begin
          next_temp = wd;
        end
        OFS_CMPC3_LO: begin
          next_cmpc = {temp, wd};
        end
        default: begin
          next_temp = next_temp;
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      flag           <= '0;
      en             <= '0;
      irq_req        <= '0;
      temp           <= RST_BYTE;
      io_rdata       <= RST_BYTE;
      t3_cmp_c_value <= RST_WORD;
    end else if (ce) begin
      flag           <= next_flag;
      en             <= next_en;
      irq_req        <= next_irq;
      temp           <= next_temp;
      io_rdata       <= next_rdata;
      t3_cmp_c_value <= next_cmpc;
    end
  end

  default clocking dclk @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence seq_cap1_low_read;
    rd && eff_off == OFS_CAP1_LO;
  endsequence

  sequence seq_cmpc_pair_write;
    (wr && eff_off == OFS_CMPC3_HI) ##1 (wr && eff_off == OFS_CMPC3_LO);
  endsequence

  AST_TEMP_LATCH: assert property (seq_cap1_low_read |=>
      temp == $past(t1_top_value[15:8]) && io_rdata == $past(t1_top_value[7:0]))
    else $error("low read did not latch the high byte");

  AST_PAIR_COMMIT: assert property (seq_cmpc_pair_write |=>
      t3_cmp_c_value == {$past(io_req.wdata, 2), $past(io_req.wdata)})
    else $error("compare C pair write not committed atomically");

  AST_IRQ_GATED: assert property (ce && !global_irq_en |=> irq_req == '0)
    else $error("interrupt requested without global enable");

  AST_IRQ_RAISE: assert property (ce && global_irq_en && flag.t1_cap && en.t1_cap |=>
      irq_req.t1_cap)
    else $error("enabled pending capture interrupt not requested");

  AST_SET_WINS: assert property (ce && set.t1_ovf |=> flag.t1_ovf)
    else $error("overflow event lost against a clear");

  AST_W1C: assert property (wr && eff_off == OFS_EFLAG && io_req.wdata[BIT_CAP]
      && !set.t3_cap |=> !flag.t3_cap)
    else $error("writing one did not clear the flag");

  AST_CMPC_FLAG: assert property (ce && t3_tick && t3_count == t3_cmp_c_value |=>
      flag.t3_cmp_c)
    else $error("compare C flag not set after match");

  AST_COMPAT_READ: assert property (rd && compat_mode && eff_off == OFS_EMASK |=>
      io_rdata == 8'h00)
    else $error("extended mask visible in compatibility mode");

  AST_DSPACE_MASK: assert property (ce && io_req.wr && io_req.dspace &&
      io_req.addr == 8'h57 |=> en.t1_cap == $past(io_req.wdata[BIT_CAP]))
    else $error("data-space write to the mask not applied");

  AST_PORT_REFUSE: assert property (ce && io_req.wr && !io_req.dspace &&
      io_req.addr == OFS_CMPC3_LO && !io_req.rd |=> $stable(t3_cmp_c_value))
    else $error("port access reached an extended register");

endmodule

//--- sim/tcr_cpu_model.sv
module tcr_cpu_model
  import tcr_pkg::*;
(
  input  wire logic       clock,
  input  wire logic [7:0] io_rdata,
  output tcr_io_req_type  io_req
);
  timeunit 1ns;
  timeprecision 100ps;

  // Bus idles until the first access
  initial io_req = '0;

  // One CPU access: mode 0 picks the path by offset, 1 forces data space, 2 raw port
  task automatic access(input logic rd, input logic wr, input logic [7:0] off,
                        input logic [7:0] wdata, input int mode, input int gap,
                        output logic [7:0] rdata);
    tcr_io_req_type req;
    req = '0;
    req.rd = rd;
    req.wr = wr;
    req.wdata = wdata;
    if (mode == 2) begin
      req.addr = off;
    end else if (mode == 0 && off <= IO_PORT_LAST) begin
      req.addr = off;
    end else begin
      req.dspace = 1'b1;
      if (off < EXT_IO_BASE) req.addr = off + DSPACE_SHIFT;
      else req.addr = off;
    end
    // Slow CPU: idle cycles before the strobe
    repeat (gap) @(negedge clock);
    @(negedge clock);
    io_req = req;
    @(negedge clock);
    io_req = '0;
    rdata = io_rdata;
  endtask

  // Back-to-back high then low write of one extended 16-bit register
  task automatic pair_write(input logic [7:0] lo_off, input logic [15:0] val);
    @(negedge clock);
    io_req = '{1'b0, 1'b1, 1'b1, 8'(lo_off + 8'h01), val[15:8]};
    @(negedge clock);
    io_req = '{1'b0, 1'b1, 1'b1, lo_off, val[7:0]};
    @(negedge clock);
    io_req = '0;
  endtask
endmodule

//--- sim/tcr_regs_tb.sv
module tcr_regs_tb
  import tcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int FBIT [10] = '{1, 2, 3, 4, 5, 0, 2, 3, 4, 5};

  logic            clock = 1'b0;
  logic            nrst = 1'b0;
  logic            ce = 1'b1;
  logic            global_irq_en = 1'b0;
  logic            compat_mode = 1'b0;
  logic            t1_cap_pin = 1'b0;
  logic            t3_cap_pin = 1'b0;
  logic            cmp_out = 1'b0;
  logic            t1_cap_from_cmp = 1'b0;
  logic            t3_tick = 1'b0;
  tcr_cfg_type     t1_cfg = '0;
  tcr_cfg_type     t3_cfg = '0;
  logic [15:0]     t1_count = 16'h0000;
  logic [15:0]     t3_count = 16'h0000;
  tcr_ext_evt_type ext_evt = '0;
  tcr_src_type     irq_ack = '0;
  tcr_src_type     irq_req;
  tcr_io_req_type  io_req;
  logic [7:0]      io_rdata;
  logic [7:0]      r;
  logic [15:0]     t1_top_value;
  logic [15:0]     t3_top_value;
  logic [15:0]     t3_cmp_c_value;
  int              errors = 0;
  int              total_checks = 0;
  int              mdl [256];
  int              temp = 0;
  int              flg = 0;
  int              v;
  int              offs [$] = '{8'h26, 8'h27, 8'h36, 8'h37, 8'h7C, 8'h7D, 8'h80, 8'h81,
                                8'h82, 8'h83};
  int              lows [$] = '{8'h82, 8'h26, 8'h80};

  // 40 MHz clock
  always #12.5 clock = ~clock;

  tcr_cpu_model cpu (.clock(clock), .io_rdata(io_rdata), .io_req(io_req));

  tcr_regs dut (.clock(clock), .nrst(nrst), .ce(ce), .io_req(io_req), .io_rdata(io_rdata),
    .global_irq_en(global_irq_en), .compat_mode(compat_mode), .t1_cap_pin(t1_cap_pin),
    .t3_cap_pin(t3_cap_pin), .cmp_out(cmp_out), .t1_cap_from_cmp(t1_cap_from_cmp),
    .t1_cfg(t1_cfg), .t3_cfg(t3_cfg), .t1_count(t1_count), .t3_count(t3_count),
    .t3_tick(t3_tick), .ext_evt(ext_evt), .irq_ack(irq_ack), .irq_req(irq_req),
    .t1_top_value(t1_top_value), .t3_top_value(t3_top_value),
    .t3_cmp_c_value(t3_cmp_c_value));

  // Compare and count
  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Reference model of a register read, with the shared high byte
  function automatic int m_read(int off);
    int b;
    b = 0;
    if (off inside {8'h26, 8'h80, 8'h82}) begin
      temp = mdl[off + 1];
      b = mdl[off];
    end else if (off inside {8'h27, 8'h81, 8'h83}) b = temp;
    else if (off == 8'h37) b = mdl[off] & 8'h3C;
    else if (off == 8'h7D) b = compat_mode ? 0 : mdl[off] & 8'h3F;
    else if (off == 8'h36 || off == 8'h7C)
      for (int s = 0; s < 10; s++)
        if (flg[s] && ((s < 6) == (off == 8'h7C))) b |= 1 << FBIT[s];
    return b;
  endfunction

  // Reference model of a register write
  function automatic void m_write(int off, int d);
    if (off inside {8'h27, 8'h81, 8'h83}) temp = d;
    else if (off inside {8'h26, 8'h80, 8'h82}) begin
      mdl[off] = d;
      mdl[off + 1] = temp;
    end else if (off == 8'h37 || (off == 8'h7D && !compat_mode)) mdl[off] = d;
    else if (off == 8'h36 || off == 8'h7C)
      for (int s = 0; s < 10; s++)
        if (d[FBIT[s]] && ((s < 6) == (off == 8'h7C))) flg[s] = 0;
  endfunction

  function automatic logic [9:0] exp_irq();
    logic [9:0] e;
    for (int s = 0; s < 10; s++)
      e[s] = flg[s] && global_irq_en &&
             (s > 5 ? mdl[8'h37][FBIT[s]] : !compat_mode && mdl[8'h7D][FBIT[s]]);
    return e;
  endfunction

  function automatic logic [15:0] word(int lo);
    return {mdl[lo + 1][7:0], mdl[lo][7:0]};
  endfunction

  task automatic bus_wr(int off, int d, int mode = 0);
    cpu.access(1'b0, 1'b1, off[7:0], d[7:0], mode, $urandom % 3, r);
    m_write(off, d & 8'hFF);
  endtask

  task automatic bus_rd(int off, int mode = 0);
    cpu.access(1'b1, 1'b0, off[7:0], 8'h00, mode, $urandom % 3, r);
    chk(16'(r), 16'(m_read(off)));
  endtask

  task automatic chk_vals();
    chk(t1_top_value, word(8'h26));
    chk(t3_top_value, word(8'h80));
    chk(t3_cmp_c_value, word(8'h82));
  endtask

  // Pin or comparator edge against a held counter value
  task automatic capture(int tmr, bit src_cmp, bit lvl, bit rising, bit top);
    logic [15:0] c;
    c = 16'($urandom);
    t1_cfg = '{rising, top};
    t3_cfg = '{rising, top};
    t1_cap_from_cmp = src_cmp;
    t1_count = c;
    t3_count = ~c;
    @(negedge clock);
    if (tmr == 3) t3_cap_pin = lvl;
    else if (src_cmp) cmp_out = lvl;
    else t1_cap_pin = lvl;
    repeat (5) @(negedge clock);
    if (!top && lvl == rising) begin
      if (tmr == 3) begin
        mdl[8'h80] = (~c) & 8'hFF;
        mdl[8'h81] = (~c) >> 8 & 8'hFF;
        flg[4] = 1;
      end else begin
        mdl[8'h26] = c & 8'hFF;
        mdl[8'h27] = c >> 8;
        flg[9] = 1;
      end
    end
    chk_vals();
    chk(16'(irq_req), 16'(exp_irq()));
    bus_rd(tmr == 3 ? 8'h7C : 8'h36);
  endtask

  // Hang guard
  initial begin
    #500000;
    errors++;
    test_done();
  end

  // Main sequence
  initial begin
    foreach (mdl[i]) mdl[i] = 0;
    void'($urandom(48));
    repeat (16) @(posedge clock);
    @(negedge clock);
    nrst = 1'b1;
    foreach (offs[i]) bus_rd(offs[i]);
    chk_vals();
    $display("test reset done");
    foreach (lows[k]) begin
      v = $urandom;
      bus_wr(lows[k] + 1, v >> 8);
      bus_wr(lows[k], v);
      chk_vals();
      bus_rd(lows[k]);
      bus_rd(lows[k] + 1);
    end
    v = $urandom;
    cpu.pair_write(8'h82, 16'(v));
    m_write(8'h83, v >> 8 & 8'hFF);
    m_write(8'h82, v & 8'hFF);
    chk_vals();
    bus_wr(8'h83, 8'h5A);
    bus_rd(8'h26);
    bus_wr(8'h82, 8'hC3);
    chk_vals();
    $display("test wide done");
    bus_wr(8'h37, 8'hFF, 1);
    bus_rd(8'h37);
    bus_wr(8'h7D, 8'hFF);
    bus_rd(8'h7D);
    cpu.access(1'b0, 1'b1, 8'h7D, 8'h00, 2, 0, r);
    cpu.access(1'b0, 1'b1, 8'h82, 8'h00, 2, 0, r);
    bus_rd(8'h7D);
    chk_vals();
    cpu.access(1'b1, 1'b0, 8'h83, 8'h00, 2, 0, r);
    chk(16'(r), 16'h003F);
    ce = 1'b0;
    cpu.access(1'b0, 1'b1, 8'h7D, 8'h00, 0, 0, r);
    ce = 1'b1;
    bus_rd(8'h7D);
    compat_mode = 1'b1;
    bus_rd(8'h7D);
    bus_wr(8'h7D, 8'h00);
    compat_mode = 1'b0;
    bus_rd(8'h7D);
    $display("test paths done");
    t1_cfg = '{1'b1, 1'b1};
    t3_cfg = '{1'b1, 1'b1};
    bus_wr(8'h37, $urandom | 8'h24);
    bus_wr(8'h7D, $urandom);
    for (int i = 0; i < 9; i++) begin
      global_irq_en = $urandom % 4 != 0;
      compat_mode = i == 4;
      @(negedge clock);
      ext_evt = 9'(1 << i);
      @(negedge clock);
      ext_evt = '0;
      flg[i + 1] = 1;
      @(negedge clock);
      chk(16'(irq_req), 16'(exp_irq()));
      bus_rd(i < 5 ? 8'h7C : 8'h36);
      if (i[0]) begin
        irq_ack = 10'(1 << (i + 1));
        @(negedge clock);
        irq_ack = '0;
        flg[i + 1] = 0;
      end else bus_wr(i < 5 ? 8'h7C : 8'h36, 1 << FBIT[i + 1]);
      @(negedge clock);
      chk(16'(irq_req), 16'(exp_irq()));
      bus_rd(i < 5 ? 8'h7C : 8'h36);
    end
    $display("test irq done");
    for (int j = 0; j < 2; j++) begin
      t3_count = word(8'h82) ^ 16'(j == 0);
      t3_tick = 1'b1;
      @(negedge clock);
      t3_tick = 1'b0;
      if (j == 1) flg[0] = 1;
      bus_rd(8'h7C);
    end
    bus_wr(8'h7C, 8'h02);
    $display("test compare done");
    global_irq_en = 1'b1;
    capture(1, 1'b0, 1'b1, 1'b1, 1'b0);
    capture(1, 1'b0, 1'b0, 1'b0, 1'b0);
    capture(3, 1'b0, 1'b1, 1'b1, 1'b0);
    capture(3, 1'b0, 1'b0, 1'b0, 1'b0);
    capture(1, 1'b1, 1'b1, 1'b1, 1'b0);
    capture(1, 1'b1, 1'b0, 1'b1, 1'b0);
    capture(1, 1'b0, 1'b1, 1'b1, 1'b1);
    bus_wr(8'h7C, 8'h20);
    bus_rd(8'h7C);
    $display("test capture done");
    test_done();
  end
endmodule
